// ==== hdl/data_address_trace_packets.sv ====
/*
  Data-address packet encoder: takes one data-transfer event at a time,
  picks the shortest legal packet format, builds its bytes and streams
  them out through a small FIFO.
  Assumes the trace analyzer keeps the same key counters and address
  queue, and that events, value-key advances and resync are synchronous.
*/
// Behaviour
// - key counters add the given increment and wrap at their limits
// - recent-address queue shifts by selector; selector 0 shifts only on far miss
// - a key at or above the right limit is special
// - encoder picks one of seven packet formats by their capabilities
// - full format handles any alignment, keys, index, special key, endianness
// - second format: word aligned, address bits 5:2 only, plain transfer
// - third format: word aligned, address bits 9:2 only, plain transfer
// - fourth format: halfword aligned, address bits 3:2 only, plain transfer
// - fifth format: no address, left key and index, no special or endianness
// - sixth format: no address, relative left key, explicit right key, index
// - seventh format only corrects the latest element's address
// - fifth and sixth formats only when address and endianness are unneeded; the code picks them on evt_no_addr_i alone, even on an endianness change
// - private peripheral space endianness may be reported either way
// - full format is a header plus at least one address byte
// - optional left key, right key, index sections follow address in order
// - upper address bytes only follow all five lower bytes
// - unsent address bits equal the selected queue entry
// - unsent key and index bits are zero
// - never more than one index byte in the full format
`include "dat_params.svh"
module data_address_trace_packets
  import dat_pkg::*;
(
  input logic mclk_i,
  input logic nrst_i,
  input logic evt_valid_i,
  output logic evt_ready_o,
  input logic [63:0] evt_addr_i,
  input logic evt_big_i,
  input logic evt_private_peripheral_space_i,
  input logic evt_no_addr_i,
  input logic evt_fix_i,
  input logic [4:0] evt_index_i,
  input logic [6:0] evt_left_inc_i,
  input logic [6:0] evt_right_inc_i,
  input logic evt_special_i,
  input logic [6:0] evt_right_key_i,
  input logic value_inc_valid_i,
  input logic [6:0] value_inc_i,
  input logic sync_clr_i,
  output logic trace_valid_o,
  input logic trace_ready_i,
  output logic [7:0] trace_data_o,
  output logic [6:0] element_left_counter_o,
  output logic [6:0] element_right_counter_o,
  output logic [6:0] value_left_counter_o,
  output logic [2:0] fmt_o
);
  typedef struct packed {
    st_t st;
    fmt_t fmt;
    logic [`MAX_PKT-1:0][7:0] pkt;
    logic [3:0] len;
    logic [3:0] pos;
    logic [6:0] elc;
    logic [6:0] erc;
    logic [6:0] vlc;
    logic big;
  } state_t;
  state_t st_r, st_nxt;

  logic fire, fifo_ready, q_upd;
  logic [63:0] q_w [3];
  logic [3:0] nb_w [3];
  logic [2:0] m2_w, m3_w, m4_w;
  logic [6:0] nl, nr, rkey;
  logic spec, big_eff, echg, plain, key_pres, idx_pres;
  logic [1:0] sel;
  fmt_t fmt_sel;
  logic [3:0] nb, p;
  logic [8:0][7:0] ab;

  // counter add with wrap; the sum fits 8 bits so the modulo is exact
  function automatic logic [6:0] wrap(input logic [6:0] c, input logic [6:0] inc,
                                      input logic [7:0] lim);
    logic [7:0] s;
    s = {1'b0, c} + {1'b0, inc};
    wrap = 7'(s % lim);
  endfunction : wrap

  function automatic logic is_special(input logic [6:0] key);
    is_special = {1'b0, key} >= `RIGHT_LIMIT;
  endfunction : is_special

  // bytes needed so that every differing bit is sent; nine means high half too
  function automatic logic [3:0] addr_len(input logic [63:0] d);
    if (d[63:32] != '0) begin
      addr_len = `FULL_ADDR_BYTES;
    end else if (d[31:28] != '0) begin
      addr_len = `LOW_ADDR_BYTES;
    end else if (d[27:21] != '0) begin
      addr_len = 4'h4;
    end else if (d[20:14] != '0) begin
      addr_len = 4'h3;
    end else if (d[13:7] != '0) begin
      addr_len = 4'h2;
    end else begin
      addr_len = 4'h1;
    end
  endfunction : addr_len

  addr_queue u_queue (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .clr_i(sync_clr_i),
    .upd_i(q_upd),
    .sel_i(sel),
    .addr_i(evt_addr_i),
    .q0_o(q_w[0]),
    .q1_o(q_w[1]),
    .q2_o(q_w[2])
  );

  // compare the new address with each queue entry
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    logic [63:0] d;
    assign d = evt_addr_i ^ q_w[i];
    assign nb_w[i] = addr_len(d);
    assign m2_w[i] = d[63:6] == '0 && d[1:0] == 2'h0;
    assign m3_w[i] = d[63:10] == '0 && d[1:0] == 2'h0;
    assign m4_w[i] = d[63:4] == '0 && d[1:0] == 2'h0;
  end

  assign evt_ready_o = st_r.st == ST_IDLE;
  assign fire = evt_valid_i && evt_ready_o;
  assign q_upd = fire && fmt_sel != FMT5 && fmt_sel != FMT6;
  assign element_left_counter_o = st_r.elc;
  assign element_right_counter_o = st_r.erc;
  assign value_left_counter_o = st_r.vlc;
  assign fmt_o = st_r.fmt;

  // event decode: new keys, endianness and the format choice
  always_comb begin
    nl = wrap(st_r.elc, evt_left_inc_i, `LEFT_LIMIT);
    nr = wrap(st_r.erc, evt_right_inc_i, `RIGHT_LIMIT);
    rkey = evt_special_i ? evt_right_key_i : nr;
    spec = is_special(rkey);
    // either endianness is legal here, so keep the last one and save a byte
    big_eff = evt_private_peripheral_space_i ? st_r.big : evt_big_i;
    echg = big_eff != st_r.big;
    key_pres = nl != 7'h00 || rkey != 7'h00;
    idx_pres = evt_index_i != 5'h00 || echg;
    // short formats imply both keys advance by one and a zero index
    plain = evt_index_i == 5'h00 && !spec && !echg && evt_left_inc_i == 7'h01 &&
            evt_right_inc_i == 7'h01 && !evt_addr_i[0];
    sel = 2'h0;
    if (nb_w[1] < nb_w[sel]) begin
      sel = 2'h1;
    end
    if (nb_w[2] < nb_w[sel]) begin
      sel = 2'h2;
    end
    fmt_sel = FMT1;
    if (evt_fix_i) begin
      fmt_sel = FMT7;
      sel = 2'h0;
    end else if (evt_no_addr_i) begin
      fmt_sel = spec ? FMT6 : FMT5;
    end else if (plain) begin
      // later loops override earlier ones: one-byte formats win
      for (int i = 2; i >= 0; i--) begin
        if (m3_w[i] && !evt_addr_i[1]) begin
          fmt_sel = FMT3;
          sel = 2'(i);
        end
      end
      for (int i = 2; i >= 0; i--) begin
        if (m4_w[i]) begin
          fmt_sel = FMT4;
          sel = 2'(i);
        end
      end
      for (int i = 2; i >= 0; i--) begin
        if (m2_w[i] && !evt_addr_i[1]) begin
          fmt_sel = FMT2;
          sel = 2'(i);
        end
      end
    end
  end

  // address section bytes for the chosen queue entry
  always_comb begin
    nb = nb_w[sel];
    ab = '0;
    for (int k = 0; k < 4; k++) begin
      ab[k] = {4'(k + 1) < nb, evt_addr_i[7*k +: 7]};
    end
    ab[4] = {nb == `FULL_ADDR_BYTES, 3'h0, evt_addr_i[31:28]};
    for (int k = 5; k < 9; k++) begin
      ab[k] = evt_addr_i[32 + 8*(k-5) +: 8];
    end
  end

  // packet builder and byte sender; the single state register
  always_comb begin
    st_nxt = st_r;
    p = 4'h0;
    if (value_inc_valid_i) begin
      st_nxt.vlc = wrap(st_r.vlc, value_inc_i, `RIGHT_LIMIT);
    end
    case (st_r.st)
      ST_IDLE: begin
        if (evt_valid_i) begin
          st_nxt.elc = nl;
          st_nxt.erc = nr;
          st_nxt.fmt = fmt_sel;
          st_nxt.pos = 4'h0;
          st_nxt.pkt = '0;
          st_nxt.st = ST_SEND;
          case (fmt_sel)
            FMT1, FMT7: begin
              st_nxt.pkt[0] = (fmt_sel == FMT1) ?
                {`F1_TOP, idx_pres, key_pres, sel} : `F7_HDR;
              for (int k = 0; k < 9; k++) begin
                if (4'(k) < nb) begin
                  st_nxt.pkt[k+1] = ab[k];
                end
              end
              p = nb + 4'h1;
              if (fmt_sel == FMT1) begin
                st_nxt.big = big_eff;
                if (key_pres) begin
                  st_nxt.pkt[p] = {1'b0, nl};
                  st_nxt.pkt[p+4'h1] = {1'b0, rkey};
                  p = p + 4'h2;
                end
                if (idx_pres) begin
                  // the index fits five bits, so one byte always suffices
                  st_nxt.pkt[p] = {1'b0, big_eff, 1'b0, evt_index_i};
                  p = p + 4'h1;
                end
              end
              st_nxt.len = p;
            end
            FMT2: begin
              st_nxt.pkt[0] = {`F2_TOP, sel, evt_addr_i[5:2]};
              st_nxt.len = 4'h1;
            end
            FMT3: begin
              st_nxt.pkt[0] = {`F3_TOP, sel};
              st_nxt.pkt[1] = evt_addr_i[9:2];
              st_nxt.len = 4'h2;
            end
            FMT4: begin
              st_nxt.pkt[0] = {`F4_TOP, sel, evt_addr_i[3:2]};
              st_nxt.len = 4'h1;
            end
            FMT5: begin
              st_nxt.pkt[0] = {`F5_TOP, 2'h0};
              st_nxt.pkt[1] = {1'b0, nl};
              st_nxt.pkt[2] = {3'h0, evt_index_i};
              st_nxt.len = 4'h3;
            end
            default: begin
              st_nxt.pkt[0] = `F6_HDR;
              st_nxt.pkt[1] = {1'b0, evt_left_inc_i};
              st_nxt.pkt[2] = {1'b0, rkey};
              st_nxt.pkt[3] = {3'h0, evt_index_i};
              st_nxt.len = 4'h4;
            end
          endcase
        end
      end
      ST_SEND: begin
        // the builder stalls here whenever the FIFO is full
        if (fifo_ready) begin
          st_nxt.pos = st_r.pos + 4'h1;
          if (st_r.pos == st_r.len - 4'h1) begin
            st_nxt.st = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  byte_fifo #(
    .WIDTH(`BYTE_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(st_r.st == ST_SEND),
    .in_ready_o(fifo_ready),
    .in_data_i(st_r.pkt[st_r.pos]),
    .out_valid_o(trace_valid_o),
    .out_ready_i(trace_ready_i),
    .out_data_o(trace_data_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  left_key_wrap_a: assert property (
    fire |=> st_r.elc == 7'(({1'b0, $past(st_r.elc)} + {1'b0, $past(evt_left_inc_i)})
      % `LEFT_LIMIT))
    else $error("left element key did not wrap correctly");

  value_key_wrap_a: assert property (
    value_inc_valid_i |=> st_r.vlc == 7'(({1'b0, $past(st_r.vlc)} +
      {1'b0, $past(value_inc_i)}) % `RIGHT_LIMIT))
    else $error("value left key did not wrap correctly");

  special_full_a: assert property (
    fire && !evt_no_addr_i && !evt_fix_i && evt_special_i &&
      {1'b0, evt_right_key_i} >= `RIGHT_LIMIT |=> st_r.fmt == FMT1)
    else $error("special key sent outside the full format");

  short_plain_a: assert property (
    fire ##1 (st_r.fmt == FMT2 || st_r.fmt == FMT3 || st_r.fmt == FMT4) |->
      $past(evt_index_i) == 5'h00 && !$past(evt_special_i) && !$past(evt_addr_i[0]))
    else $error("short format used for a transfer it cannot describe");

  no_addr_only_a: assert property (
    fire && !evt_no_addr_i |=> st_r.fmt != FMT5 && st_r.fmt != FMT6)
    else $error("address-free format used while the address is needed");

  full_header_a: assert property (
    st_r.st == ST_SEND && st_r.pos == 4'h0 && st_r.fmt == FMT1 |->
      st_r.pkt[0][7:4] == `F1_TOP && st_r.len >= 4'h2)
    else $error("full format header or address byte missing");

  high_flag_a: assert property (
    st_r.st == ST_SEND && st_r.fmt == FMT1 && st_r.pkt[5][`HIGH_FLAG_BIT] &&
      st_r.pkt[4][`CONT_BIT] |-> st_r.len >= 4'hA)
    else $error("high address flag without the upper bytes");

  index_last_a: assert property (
    st_r.st == ST_SEND && st_r.fmt == FMT1 && st_r.pkt[0][`CODE_INDEX_BIT] |->
      !st_r.pkt[st_r.len - 4'h1][`CONT_BIT])
    else $error("full format index section longer than one byte");

  send_bounded_a: assert property (
    fire |-> ##[1:60] evt_ready_o)
    else $error("packet not drained in time");
endmodule : data_address_trace_packets

// ==== hdl/dat_params.svh ====
/*
  Constants of the data-address packet encoder: key limits, header codes,
  bit positions, packet and FIFO sizes.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef DAT_PARAMS_SVH
`define DAT_PARAMS_SVH

// association key limits (counters wrap at these)
`define LEFT_LIMIT 8'h20
`define RIGHT_LIMIT 8'h20

// header codes per packet format
`define F1_TOP 4'h7
`define F2_TOP 2'h2
`define F3_TOP 6'h30
`define F4_TOP 4'hE
`define F5_TOP 6'h08
`define F6_HDR 8'h30
`define F7_HDR 8'h34

// byte-level field positions
`define CONT_BIT 7
`define HIGH_FLAG_BIT 7
`define ENDIAN_BIT 6
`define CODE_KEYS_BIT 2
`define CODE_INDEX_BIT 3

// sizes
`define MAX_PKT 13
`define FULL_ADDR_BYTES 4'h9
`define LOW_ADDR_BYTES 4'h5
`define FIFO_DEPTH 4
`define BYTE_W 8

`endif

// ==== hdl/dat_pkg.sv ====
/*
  Types shared by the data-address packet encoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dat_pkg;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_SEND = 1'b1} st_t;
  typedef enum logic [2:0] {
    FMT1 = 3'b000, FMT2 = 3'b001, FMT3 = 3'b010, FMT4 = 3'b011,
    FMT5 = 3'b100, FMT6 = 3'b101, FMT7 = 3'b110
  } fmt_t;
endpackage : dat_pkg

// ==== hdl/byte_fifo.sv ====
/*
  Small FIFO between the packet builder and the trace byte port.
  Assumes DEPTH is a power of two; one clock, synchronous reset.
*/
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input logic mclk_i,
  input logic nrst_i,
  input logic in_valid_i,
  output logic in_ready_o,
  input logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;
  fifo_t fifo_r, fifo_nxt;
  logic push, pop;

  // full and empty straight from the count, so back-pressure is exact
  assign in_ready_o = fifo_r.cnt != FULL;
  assign out_valid_o = fifo_r.cnt != '0;
  assign out_data_o = fifo_r.mem[fifo_r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb begin
    fifo_nxt = fifo_r;
    if (push) begin
      fifo_nxt.mem[fifo_r.wp] = in_data_i;
      fifo_nxt.wp = fifo_r.wp + 1'b1;
    end
    if (pop) begin
      fifo_nxt.rp = fifo_r.rp + 1'b1;
    end
    fifo_nxt.cnt = fifo_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fifo_r <= '0;
    end else begin
      fifo_r <= fifo_nxt;
    end
  end
endmodule : byte_fifo

// ==== hdl/addr_queue.sv ====
/*
  Three-entry queue of recently traced data addresses.
  Assumes the encoder drives one update per traced address and a clear
  whenever the trace stream is resynchronised.
*/
module addr_queue (
  input logic mclk_i,
  input logic nrst_i,
  input logic clr_i,
  input logic upd_i,
  input logic [1:0] sel_i,
  input logic [63:0] addr_i,
  output logic [63:0] q0_o,
  output logic [63:0] q1_o,
  output logic [63:0] q2_o
);
  typedef struct packed {
    logic [63:0] q2;
    logic [63:0] q1;
    logic [63:0] q0;
  } queue_t;
  queue_t q_r, q_nxt;

  assign q0_o = q_r.q0;
  assign q1_o = q_r.q1;
  assign q2_o = q_r.q2;

  // shift pattern depends on which entry the packet was coded against
  always_comb begin
    q_nxt = q_r;
    if (clr_i) begin
      q_nxt = '0;
    end else if (upd_i) begin
      case (sel_i)
        2'h2: begin
          q_nxt.q2 = q_r.q1;
          q_nxt.q1 = q_r.q0;
        end
        2'h1: begin
          q_nxt.q1 = q_r.q0;
        end
        default: begin
          // a near hit on entry 0 refreshes it without pushing the queue
          if (addr_i[63:6] != q_r.q0[63:6]) begin
            q_nxt.q2 = q_r.q1;
            q_nxt.q1 = q_r.q0;
          end
        end
      endcase
      q_nxt.q0 = addr_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  queue_shift_two_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    upd_i && !clr_i && sel_i == 2'h2 |=>
      q_r.q2 == $past(q_r.q1) && q_r.q1 == $past(q_r.q0) && q_r.q0 == $past(addr_i))
    else $error("queue did not shift for selector two");

  queue_near_keep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    upd_i && !clr_i && sel_i == 2'h0 && addr_i[63:6] == q_r.q0[63:6] |=>
      $stable(q_r.q1) && $stable(q_r.q2))
    else $error("queue shifted on a near hit");
endmodule : addr_queue

// ==== tb/trace_sink.sv ====
/*
  Behavioural trace analyzer: takes bytes off the trace port and keeps
  them in arrival order for the bench to inspect.
  Assumes one clock shared with the encoder and a synchronous low reset.
*/
module trace_sink (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  input wire logic trace_valid_i,
  input wire logic [7:0] trace_data_i,
  output logic trace_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [1:0] phase_r;

  // stall pattern: when slow, accept one cycle in four so the FIFO fills
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign trace_ready_o = !slow_i || (phase_r == 2'h3);

  // capture each byte at the edge where it is handed over
  always @(posedge mclk_i) begin
    if (nrst_i && trace_valid_i && trace_ready_o) begin
      got_q.push_back(trace_data_i);
    end
  end
endmodule : trace_sink

// ==== tb/data_address_trace_packets_tb_top.sv ====
/*
  Self-checking bench of the data-address packet encoder: offers events,
  collects the byte stream through the analyzer model and compares it.
  Assumes the encoder's package and the analyzer model compile first.
*/
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp); end end
module data_address_trace_packets_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dat_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic evt_valid_i = 1'b0;
  logic evt_ready_o;
  logic [63:0] evt_addr_i = 64'h0;
  logic evt_big_i = 1'b0;
  logic evt_private_peripheral_space_i = 1'b0;
  logic evt_no_addr_i = 1'b0;
  logic evt_fix_i = 1'b0;
  logic [4:0] evt_index_i = 5'h0;
  logic [6:0] evt_left_inc_i = 7'h0;
  logic [6:0] evt_right_inc_i = 7'h0;
  logic evt_special_i = 1'b0;
  logic [6:0] evt_right_key_i = 7'h0;
  logic value_inc_valid_i = 1'b0;
  logic [6:0] value_inc_i = 7'h0;
  logic sync_clr_i = 1'b0;
  logic trace_valid_o;
  logic trace_ready_i;
  logic [7:0] trace_data_o;
  logic [6:0] element_left_counter_o;
  logic [6:0] element_right_counter_o;
  logic [6:0] value_left_counter_o;
  logic [2:0] fmt_o;
  logic slow = 1'b0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 mclk_i = ~mclk_i;

  data_address_trace_packets u_data_address_trace_packets (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .evt_valid_i(evt_valid_i), .evt_ready_o(evt_ready_o), .evt_addr_i(evt_addr_i),
    .evt_big_i(evt_big_i),
    .evt_private_peripheral_space_i(evt_private_peripheral_space_i),
    .evt_no_addr_i(evt_no_addr_i),
    .evt_fix_i(evt_fix_i), .evt_index_i(evt_index_i), .evt_left_inc_i(evt_left_inc_i),
    .evt_right_inc_i(evt_right_inc_i), .evt_special_i(evt_special_i),
    .evt_right_key_i(evt_right_key_i), .value_inc_valid_i(value_inc_valid_i),
    .value_inc_i(value_inc_i), .sync_clr_i(sync_clr_i), .trace_valid_o(trace_valid_o),
    .trace_ready_i(trace_ready_i), .trace_data_o(trace_data_o),
    .element_left_counter_o(element_left_counter_o),
    .element_right_counter_o(element_right_counter_o),
    .value_left_counter_o(value_left_counter_o), .fmt_o(fmt_o));

  trace_sink u_trace_sink (.mclk_i(mclk_i), .nrst_i(nrst_i), .slow_i(slow),
    .trace_valid_i(trace_valid_o), .trace_data_i(trace_data_o),
    .trace_ready_o(trace_ready_i));

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ctl is {big, private space, no address, fix, special}; exp_q holds the bytes
  task automatic send_evt(input logic [63:0] a, input logic [4:0] ctl, input logic [4:0] ix,
    input logic [6:0] li, input logic [6:0] ri, input logic [6:0] rk, input fmt_t f);
    int n;
    n = 0;
    u_trace_sink.got_q.delete();
    while (evt_ready_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    {evt_big_i, evt_private_peripheral_space_i, evt_no_addr_i, evt_fix_i, evt_special_i} = ctl;
    evt_addr_i = a;
    evt_index_i = ix;
    evt_left_inc_i = li;
    evt_right_inc_i = ri;
    evt_right_key_i = rk;
    evt_valid_i = 1'b1;
    @(negedge mclk_i);
    evt_valid_i = 1'b0;
    n = 0;
    // wait for the whole packet, then a while longer to catch extra bytes
    while (u_trace_sink.got_q.size() < exp_q.size() && n < 300) begin
      @(negedge mclk_i);
      n++;
    end
    repeat (8) @(negedge mclk_i);
    `CHK(u_trace_sink.got_q.size(), exp_q.size())
    foreach (exp_q[i]) begin
      if (i < u_trace_sink.got_q.size()) begin
        `CHK(u_trace_sink.got_q[i], exp_q[i])
      end
    end
    `CHK(fmt_o, f)
  endtask : send_evt

  task automatic t_reset();
    `CHK(evt_ready_o, 1'b1)
    `CHK(trace_valid_o, 1'b0)
    `CHK(element_left_counter_o, 7'h00)
    `CHK(value_left_counter_o, 7'h00)
  endtask : t_reset

  // word-aligned near misses against the zeroed queue
  task automatic t_short();
    exp_q = '{8'h89};
    send_evt(64'h24, 5'h00, 5'h0, 7'h01, 7'h01, 7'h00, FMT2);
    exp_q = '{8'hC0, 8'h69};
    send_evt(64'h1A4, 5'h00, 5'h0, 7'h01, 7'h01, 7'h00, FMT3);
    `CHK(element_left_counter_o, 7'h02)
    `CHK(element_right_counter_o, 7'h02)
  endtask : t_short

  // full format: index forces it, then a 13-byte packet through a stalled sink
  task automatic t_full();
    exp_q = '{8'h78, 8'h24, 8'h03};
    send_evt(64'h1A4, 5'h00, 5'h03, 7'h1E, 7'h1E, 7'h00, FMT1);
    `CHK(element_left_counter_o, 7'h00)
    `CHK(element_right_counter_o, 7'h00)
    slow = 1'b1;
    exp_q = '{8'h7C, 8'h84, 8'h80, 8'h80, 8'h80, 8'h80, 8'h01, 8'h00, 8'h00, 8'h00,
              8'h01, 8'h01, 8'h40};
    send_evt(64'h1_0000_0004, 5'h10, 5'h0, 7'h01, 7'h01, 7'h00, FMT1);
    slow = 1'b0;
  endtask : t_full

  // address-free elements, a special right key at the limit, then a fix-up
  task automatic t_noaddr();
    exp_q = '{8'h20, 8'h03, 8'h05};
    send_evt(64'h0, 5'h14, 5'h05, 7'h02, 7'h01, 7'h00, FMT5);
    exp_q = '{8'h30, 8'h04, 8'h20, 8'h01};
    send_evt(64'h0, 5'h15, 5'h01, 7'h04, 7'h01, 7'h20, FMT6);
    `CHK(element_left_counter_o, 7'h07)
    `CHK(element_right_counter_o, 7'h03)
    exp_q = '{8'h34, 8'h08};
    send_evt(64'h1_0000_0008, 5'h12, 5'h0, 7'h00, 7'h00, 7'h00, FMT7);
    `CHK(element_left_counter_o, 7'h07)
  endtask : t_noaddr

  // two back-to-back advances of the value key wrap at the right limit
  task automatic t_value();
    value_inc_i = 7'h14;
    value_inc_valid_i = 1'b1;
    @(negedge mclk_i);
    @(negedge mclk_i);
    value_inc_valid_i = 1'b0;
    @(negedge mclk_i);
    `CHK(value_left_counter_o, 7'h08)
  endtask : t_value

  // after a clear the queue is zero; private space keeps the big endianness
  task automatic t_sync();
    sync_clr_i = 1'b1;
    @(negedge mclk_i);
    sync_clr_i = 1'b0;
    @(negedge mclk_i);
    exp_q = '{8'h81};
    send_evt(64'h04, 5'h08, 5'h0, 7'h01, 7'h01, 7'h00, FMT2);
  endtask : t_sync

  // special key with an address, then short formats against queue entry two
  task automatic t_near();
    exp_q = '{8'h74, 8'h82, 8'h80, 8'h80, 8'h80, 8'h01, 8'h09, 8'h20};
    send_evt(64'h1000_0002, 5'h11, 5'h0, 7'h01, 7'h01, 7'h20, FMT1);
    exp_q = '{8'h7C, 8'h80, 8'h80, 8'h80, 8'h80, 8'h02, 8'h0A, 8'h06, 8'h41};
    send_evt(64'h2000_0000, 5'h10, 5'h01, 7'h01, 7'h01, 7'h00, FMT1);
    exp_q = '{8'hA2};
    send_evt(64'h8, 5'h10, 5'h0, 7'h01, 7'h01, 7'h00, FMT2);
    exp_q = '{8'hEB};
    send_evt(64'h1000_000E, 5'h10, 5'h0, 7'h01, 7'h01, 7'h00, FMT4);
    `CHK(element_left_counter_o, 7'h0C)
    `CHK(element_right_counter_o, 7'h08)
  endtask : t_near

  initial begin
    repeat (12) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_reset();
    t_short();
    t_full();
    t_noaddr();
    t_value();
    t_sync();
    t_near();
    finish_test();
  end
endmodule : data_address_trace_packets_tb_top
